/* rtl/isc_serial_ctrl.sv */
// dispatch serialization control: holds, blocks, flushes and splits instructions
// assumes dispatch, completion and execution neighbours on the same clock
module isc_serial_ctrl
	import isc_pkg::*;
#(
	parameter int UNITS = NUM_UNITS
)(
	// clock and reset
	input  wire logic                    clock,
	input  wire logic                    rstn,
	// configuration
	input  wire isc_mode_e               mode,
	// dispatch request
	input  wire logic                    reqValid,
	input  wire isc_req_s                req,
	output      logic                    reqReady,
	// completion side
	input  wire logic                    retireValid,
	input  wire logic [TAG_W-1:0]        retireTag,
	input  wire logic                    oldestValid,
	input  wire logic [TAG_W-1:0]        oldestTag,
	// execution side
	input  wire logic                    moveDoneValid,
	input  wire logic [TAG_W-1:0]        moveDoneTag,
	// dispatch and control outputs
	output      isc_disp_s               disp,
	output      isc_tagev_s              execGo,
	output      isc_tagev_s              flush,
	output      logic                    moveBlock,
	output      logic                    serialBlock,
	// unit status and results
	output      logic [UNITS-1:0]        unitFree,
	output      isc_result_s [UNITS-1:0] result
);

	isc_state_e        state, next_state;
	logic [WORD_W-1:0] wordsLeft, next_wordsLeft;
	logic [WORD_W-1:0] wordIdx, next_wordIdx;
	logic [UNIT_W-1:0] splitUnit, next_splitUnit;
	logic [TAG_W-1:0]  curTag, next_curTag;
	logic              refetch, next_refetch;
	isc_start_s        hold, next_hold;
	logic [UNIT_W-1:0] holdUnit, next_holdUnit;
	logic              next_moveBlock;
	logic [TAG_W-1:0]  moveTag, next_moveTag;
	isc_disp_s         next_disp;
	isc_tagev_s        next_execGo, next_flush;
	logic              next_reqReady;
	logic              next_serialBlock;

	isc_ser_e          eff;
	logic [UNIT_W-1:0] unitSel;
	isc_start_s        timing;
	logic              blocked, take;
	isc_start_s [UNITS-1:0] start;

	//////////////////////////////////////////////////////////////////////
	// request decode
	always_comb begin
		eff     = isc_eff_class(mode, req);
		unitSel = req.isBranch ? UNIT_BRANCH : req.unit;
		timing.valid     = 1'b1;
		timing.tag       = req.tag;
		timing.execTime  = req.execTime;
		timing.latGpr    = req.latGpr;
		timing.latCr     = req.latCr;
		timing.recording = req.recording;
		if (req.isBranch) begin
			timing.execTime  = BRANCH_EXEC_TIME;
			timing.recording = 1'b0;
		end else if (req.isCrLogic) begin
			timing.execTime = CRLOGIC_EXEC_TIME;
			timing.latGpr   = CRLOGIC_LATENCY;
			timing.latCr    = CRLOGIC_LATENCY;
		end
		blocked = (moveBlock && mode == MODE_OOO && (req.isMove || req.isBranch || req.isCrLogic))
			|| (hold.valid && (eff == SER_COMPLETION || eff == SER_EXECUTION))
			|| (hold.valid && holdUnit == unitSel)
			|| !unitFree[unitSel];
		take = reqValid && reqReady && (state == ST_RUN) && !blocked;
	end

	//////////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		next_state     = state;
		next_wordsLeft = wordsLeft;
		next_wordIdx   = wordIdx;
		next_splitUnit = splitUnit;
		next_curTag    = curTag;
		next_refetch   = refetch;
		next_hold      = hold;
		next_holdUnit  = holdUnit;
		next_moveBlock = moveBlock;
		next_moveTag   = moveTag;
		next_disp      = '0;
		next_execGo    = '0;
		next_flush     = '0;
		start          = '0;
		for (int u = 0; u < UNITS; u++) begin
			start[u] = '0;
		end
		unique case (state)
			ST_RUN: begin
				if (take) begin
					next_disp.valid = 1'b1;
					next_disp.tag   = req.tag;
					next_disp.unit  = unitSel;
					next_disp.word  = WORD_ZERO;
					next_disp.last  = 1'b1;
					next_curTag     = req.tag;
					start[unitSel]  = timing;
					unique case (eff)
						SER_SYNC, SER_DISPATCH, SER_REFETCH: begin
							next_state   = ST_BLOCK;
							next_refetch = (eff == SER_REFETCH);
						end
						SER_COMPLETION, SER_EXECUTION: begin
							next_disp.held = 1'b1;
							next_hold      = timing;
							next_holdUnit  = unitSel;
							start[unitSel] = '0;
						end
						SER_POSTDISPATCH: begin
							next_flush.valid = 1'b1;
							next_flush.tag   = req.tag;
						end
						SER_STRMULT: begin
							if (req.wordCount > WORD_ONE) begin
								next_state     = ST_SPLIT;
								next_disp.last = 1'b0;
								next_wordsLeft = req.wordCount - WORD_ONE;
								next_wordIdx   = WORD_ZERO;
								next_splitUnit = unitSel;
							end
						end
						SER_NONE: begin
						end
					endcase
					if (mode == MODE_OOO && req.isMove) begin
						next_moveBlock = 1'b1;
						next_moveTag   = req.tag;
					end
				end
			end
			ST_SPLIT: begin
				next_disp.valid = 1'b1;
				next_disp.tag   = curTag;
				next_disp.unit  = splitUnit;
				next_disp.word  = wordIdx + WORD_ONE;
				next_disp.last  = (wordsLeft == WORD_ONE);
				next_wordIdx    = wordIdx + WORD_ONE;
				next_wordsLeft  = wordsLeft - WORD_ONE;
				if (wordsLeft == WORD_ONE)
					next_state = ST_RUN;
			end
			ST_BLOCK: begin
				if (retireValid && retireTag == curTag) begin
					next_state = ST_RUN;
					if (refetch) begin
						next_flush.valid = 1'b1;
						next_flush.tag   = curTag;
					end
				end
			end
			default: next_state = ST_RUN;
		endcase
		// a held instruction starts once it is the oldest uncompleted one
		if (hold.valid && oldestValid && oldestTag == hold.tag) begin
			next_hold.valid   = 1'b0;
			next_execGo.valid = 1'b1;
			next_execGo.tag   = hold.tag;
			start[holdUnit]   = hold;
		end
		// a new move cannot be taken while one is pending, so clear never meets set
		if (moveBlock && moveDoneValid && moveDoneTag == moveTag)
			next_moveBlock = 1'b0;
		next_reqReady    = (next_state == ST_RUN) && !take;
		next_serialBlock = (next_state == ST_BLOCK);
	end

	//////////////////////////////////////////////////////////////////////
	always_ff @(posedge clock) begin
		if (!rstn) begin
			state       <= ST_RUN;
			wordsLeft   <= WORD_ZERO;
			wordIdx     <= WORD_ZERO;
			splitUnit   <= UNIT_BRANCH;
			curTag      <= '0;
			refetch     <= 1'b0;
			hold        <= '0;
			holdUnit    <= UNIT_BRANCH;
			moveBlock   <= 1'b0;
			moveTag     <= '0;
			disp        <= '0;
			execGo      <= '0;
			flush       <= '0;
			reqReady    <= 1'b0;
			serialBlock <= 1'b0;
		end else begin
			state       <= next_state;
			wordsLeft   <= next_wordsLeft;
			wordIdx     <= next_wordIdx;
			splitUnit   <= next_splitUnit;
			curTag      <= next_curTag;
			refetch     <= next_refetch;
			hold        <= next_hold;
			holdUnit    <= next_holdUnit;
			moveBlock   <= next_moveBlock;
			moveTag     <= next_moveTag;
			disp        <= next_disp;
			execGo      <= next_execGo;
			flush       <= next_flush;
			reqReady    <= next_reqReady;
			serialBlock <= next_serialBlock;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// per-unit execution timers
	for (genvar g = 0; g < UNITS; g++) begin : gUnit
		isc_unit_timer uTimer (
			.clock  (clock),
			.rstn   (rstn),
			.start  (start[g]),
			.free   (unitFree[g]),
			.result (result[g])
		);
	end

endmodule // isc_serial_ctrl

/* rtl/isc_pkg.sv */
// shared types and constants of the instruction serialization control
// assumes one core clock; all neighbours are synchronous logic on that clock
package isc_pkg;

	localparam int TAG_W     = 4;
	localparam int CNT_W     = 6;
	localparam int WORD_W    = 5;
	localparam int UNIT_W    = 2;
	localparam int NUM_UNITS = 4;

	// execution unit indices
	localparam logic [UNIT_W-1:0] UNIT_BRANCH    = 2'h0; // branch_processing_unit
	localparam logic [UNIT_W-1:0] UNIT_SYSREG    = 2'h1; // system_register_unit
	localparam logic [UNIT_W-1:0] UNIT_FIXED     = 2'h2; // fixed_point_unit
	localparam logic [UNIT_W-1:0] UNIT_LOADSTORE = 2'h3;

	// fixed timing of branches and condition-register logicals, then counter and word constants
	localparam logic [CNT_W-1:0]  BRANCH_EXEC_TIME  = 6'h01;
	localparam logic [CNT_W-1:0]  CRLOGIC_EXEC_TIME = 6'h01;
	localparam logic [CNT_W-1:0]  CRLOGIC_LATENCY   = 6'h01;
	localparam logic [CNT_W-1:0]  CNT_ZERO          = 6'h00;
	localparam logic [CNT_W-1:0]  CNT_ONE           = 6'h01;
	localparam logic [WORD_W-1:0] WORD_ZERO         = 5'h00;
	localparam logic [WORD_W-1:0] WORD_ONE          = 5'h01;

	typedef enum logic [1:0] {MODE_TAGFLOW, MODE_INORDER, MODE_OOO} isc_mode_e;

	typedef enum logic [2:0] {
		SER_NONE, SER_SYNC, SER_COMPLETION, SER_DISPATCH,
		SER_REFETCH, SER_EXECUTION, SER_POSTDISPATCH, SER_STRMULT
	} isc_ser_e;

	typedef enum logic [1:0] {ST_RUN, ST_SPLIT, ST_BLOCK} isc_state_e;

	typedef struct packed {
		logic [TAG_W-1:0]  tag;
		isc_ser_e          serClass;
		logic [UNIT_W-1:0] unit;
		logic              isMove;
		logic              isBranch;
		logic              isCrLogic;
		logic              recording;
		logic [CNT_W-1:0]  execTime;
		logic [CNT_W-1:0]  latGpr;
		logic [CNT_W-1:0]  latCr;
		logic [WORD_W-1:0] wordCount;
	} isc_req_s;

	typedef struct packed {
		logic              valid;
		logic [TAG_W-1:0]  tag;
		logic [UNIT_W-1:0] unit;
		logic [WORD_W-1:0] word;
		logic              last;
		logic              held;
	} isc_disp_s;

	typedef struct packed {
		logic             valid;
		logic [TAG_W-1:0] tag;
	} isc_tagev_s;

	typedef struct packed {
		logic             valid;
		logic [TAG_W-1:0] tag;
		logic [CNT_W-1:0] execTime;
		logic [CNT_W-1:0] latGpr;
		logic [CNT_W-1:0] latCr;
		logic             recording;
	} isc_start_s;

	typedef struct packed {
		logic             gprValid;
		logic             crValid;
		logic [TAG_W-1:0] tag;
	} isc_result_s;

	// serialization that an instruction really gets in the current mode
	function automatic isc_ser_e isc_eff_class(input isc_mode_e mode, input isc_req_s r);
		isc_ser_e c;
		c = SER_NONE;
		if (r.isBranch) begin
			c = SER_NONE;
		end else if (mode == MODE_TAGFLOW) begin
			c = (r.serClass == SER_SYNC) ? SER_SYNC : SER_NONE;
		end else if (mode == MODE_INORDER) begin
			if (r.isCrLogic)
				c = SER_COMPLETION;
			else if (r.serClass == SER_COMPLETION || r.serClass == SER_DISPATCH || r.serClass == SER_REFETCH)
				c = r.serClass;
		end else if (mode == MODE_OOO) begin
			if (r.isCrLogic)
				c = SER_EXECUTION;
			else if (r.serClass == SER_EXECUTION || r.serClass == SER_POSTDISPATCH || r.serClass == SER_STRMULT)
				c = r.serClass;
		end
		return c;
	endfunction

	function automatic logic [CNT_W-1:0] isc_at_least_one(input logic [CNT_W-1:0] v);
		return (v == CNT_ZERO) ? CNT_ONE : v;
	endfunction

endpackage

/* rtl/isc_unit_timer.sv */
// occupancy and result-latency timer of one execution unit
// assumes at most one start per cycle and one result outstanding per unit
module isc_unit_timer
	import isc_pkg::*;
(
	// clock and reset
	input  wire logic        clock,
	input  wire logic        rstn,
	// start of execution
	input  wire isc_start_s  start,
	// status and results
	output      logic        free,
	output      isc_result_s result
);

	logic [CNT_W-1:0] execLeft, gprLeft, crLeft;
	logic [CNT_W-1:0] next_execLeft, next_gprLeft, next_crLeft;
	logic [TAG_W-1:0] tag, next_tag;
	logic             recording, next_recording;
	logic             next_free;
	isc_result_s      next_result;

	//////////////////////////////////////////////////////////////////////
	always_comb begin
		next_execLeft  = (execLeft == CNT_ZERO) ? CNT_ZERO : execLeft - CNT_ONE;
		next_gprLeft   = (gprLeft == CNT_ZERO) ? CNT_ZERO : gprLeft - CNT_ONE;
		next_crLeft    = (crLeft == CNT_ZERO) ? CNT_ZERO : crLeft - CNT_ONE;
		next_tag       = tag;
		next_recording = recording;
		next_result.gprValid = (gprLeft == CNT_ONE);
		next_result.crValid  = (crLeft == CNT_ONE) && recording;
		next_result.tag      = tag;
		if (start.valid) begin
			next_execLeft  = isc_at_least_one(start.execTime);
			next_gprLeft   = isc_at_least_one(start.latGpr);
			next_crLeft    = isc_at_least_one(start.latCr);
			next_tag       = start.tag;
			next_recording = start.recording;
		end
		// unit takes the next independent instruction as the execution time elapses
		next_free = (next_execLeft <= CNT_ONE);
	end

	//////////////////////////////////////////////////////////////////////
	always_ff @(posedge clock) begin
		if (!rstn) begin
			execLeft  <= CNT_ZERO;
			gprLeft   <= CNT_ZERO;
			crLeft    <= CNT_ZERO;
			tag       <= '0;
			recording <= 1'b0;
			free      <= 1'b1;
			result    <= '0;
		end else begin
			execLeft  <= next_execLeft;
			gprLeft   <= next_gprLeft;
			crLeft    <= next_crLeft;
			tag       <= next_tag;
			recording <= next_recording;
			free      <= next_free;
			result    <= next_result;
		end
	end

endmodule // isc_unit_timer

/* tb/isc_serial_ctrl_sva.sv */
// assertions on the ports of the serialization control
// assumes one core clock and the synchronous reset rstn
module isc_serial_ctrl_sva
	import isc_pkg::*;
(
	// clock and reset
	input wire logic             clock,
	input wire logic             rstn,
	// inputs of the block
	input wire isc_mode_e        mode,
	input wire logic             reqValid,
	input wire isc_req_s         req,
	input wire logic             retireValid,
	input wire logic [TAG_W-1:0] retireTag,
	input wire logic             oldestValid,
	input wire logic [TAG_W-1:0] oldestTag,
	// outputs of the block
	input wire logic             reqReady,
	input wire isc_disp_s        disp,
	input wire isc_tagev_s       execGo,
	input wire isc_tagev_s       flush,
	input wire logic             moveBlock,
	input wire logic             serialBlock
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);
	wire logic taking = reqValid && reqReady;
	wire logic blockKind = req.isMove || req.isBranch || req.isCrLogic;
	////////////////////////////////////////////////////////////////
	chk_serial_no_disp: assert property (serialBlock |=> !disp.valid)
		else $error("dispatch while serialized");
	chk_move_blocks: assert property (moveBlock && taking && blockKind |=> !disp.valid)
		else $error("blocked kind dispatched under move");
	chk_exec_oldest: assert property (execGo.valid |-> $past(oldestValid) && $past(oldestTag) == execGo.tag)
		else $error("held instruction released while not oldest");
	chk_postdisp_flush: assert property (taking && mode == MODE_OOO && req.serClass == SER_POSTDISPATCH
		&& !blockKind |=> flush.valid == disp.valid && (!flush.valid || flush.tag == $past(req.tag)))
		else $error("postdispatch flush missing");
	chk_string_rate: assert property (disp.valid && !disp.last |=> disp.valid && disp.tag == $past(disp.tag)
		&& disp.word == $past(disp.word) + WORD_ONE)
		else $error("string words not one per cycle");
	chk_branch_free: assert property (taking && req.isBranch |=> !serialBlock && !disp.held)
		else $error("branch serialized");
	chk_tagflow_plain: assert property (taking && mode == MODE_TAGFLOW && req.serClass != SER_SYNC
		|=> !serialBlock && !disp.held)
		else $error("tag-flow plain instruction serialized");
	chk_refetch_after: assert property (flush.valid && mode == MODE_INORDER
		|-> $past(retireValid) && $past(retireTag) == flush.tag)
		else $error("refetch flush without retire");
	cov_string_end: cover property (disp.valid && disp.last && disp.word == 5'h02);
	cov_exec_go: cover property (execGo.valid);
	cov_flush: cover property (flush.valid);
endmodule // isc_serial_ctrl_sva

bind isc_serial_ctrl isc_serial_ctrl_sva isc_serial_ctrl_sva_i (.clock(clock), .rstn(rstn), .mode(mode),
	.reqValid(reqValid), .req(req), .retireValid(retireValid), .retireTag(retireTag), .oldestValid(oldestValid),
	.oldestTag(oldestTag), .reqReady(reqReady), .disp(disp), .execGo(execGo), .flush(flush),
	.moveBlock(moveBlock), .serialBlock(serialBlock));

/* tb/isc_core_model.sv */
// completion and execution side: keeps dispatched tags in program order
// retires the oldest after a delay, a held one only after its release
module isc_core_model
	import isc_pkg::*;
(
	// clock and reset
	input  wire logic             clock,
	input  wire logic             rstn,
	// dispatch side
	input  wire isc_disp_s        disp,
	input  wire isc_tagev_s       execGo,
	input  wire logic             slow,
	// completion and execution answers
	output      logic             retireValid,
	output      logic [TAG_W-1:0] retireTag,
	output      logic             oldestValid,
	output      logic [TAG_W-1:0] oldestTag,
	output      logic             moveDoneValid,
	output      logic [TAG_W-1:0] moveDoneTag
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [TAG_W-1:0] tags[$];
	logic             held[$];
	logic             goSeen = 1'b0;
	int               age = 0;
	initial {retireValid, retireTag, oldestValid, oldestTag, moveDoneValid, moveDoneTag} = '0;
	////////////////////////////////////////////////////////////////
	always @(negedge clock) begin
		retireValid = 1'b0;
		moveDoneValid = 1'b0;
		// idle tags show the inverse of the last value
		retireTag = ~retireTag;
		moveDoneTag = ~moveDoneTag;
		if (rstn !== 1'b1) begin
			tags.delete();
			held.delete();
			age = 0;
			goSeen = 1'b0;
		end else begin
			if (disp.valid === 1'b1 && disp.word === WORD_ZERO) begin
				tags.push_back(disp.tag);
				held.push_back(disp.held);
			end
			if (tags.size() > 0 && execGo.valid === 1'b1 && execGo.tag === tags[0])
				goSeen = 1'b1;
			if (tags.size() > 0 && (held[0] !== 1'b1 || goSeen))
				age++;
			if (age > (slow ? 6 : 1)) begin
				retireValid = 1'b1;
				retireTag = tags[0];
				moveDoneValid = 1'b1;
				moveDoneTag = tags[0];
				tags.pop_front();
				held.pop_front();
				age = 0;
				goSeen = 1'b0;
			end
		end
		oldestValid = tags.size() > 0;
		oldestTag = oldestValid ? tags[0] : ~oldestTag;
	end
endmodule // isc_core_model

/* tb/tb_top.sv */
// self-checking bench of the serialization control
// assumes the core model on the completion side and the bound checker
module tb_top
	import isc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic                        clock = 1'b0, rstn = 1'b0, slow = 1'b0, reqValid = 1'b0;
	isc_mode_e                   mode = MODE_INORDER;
	isc_req_s                    req = '0;
	logic                        reqReady, retireValid, oldestValid, moveDoneValid, moveBlock, serialBlock;
	logic [TAG_W-1:0]            retireTag, oldestTag, moveDoneTag, flushTag;
	isc_disp_s                   disp;
	isc_tagev_s                  execGo, flush;
	logic [NUM_UNITS-1:0]        unitFree;
	isc_result_s [NUM_UNITS-1:0] result;
	int miscompares = 0, n_tests = 0, cycles = 0, nRet = 0, nMove = 0, nFlush = 0, gprAt = 0, crAt = 0;
	always #50 clock = ~clock;
	isc_serial_ctrl isc_serial_ctrl_i (.clock(clock), .rstn(rstn), .mode(mode), .reqValid(reqValid), .req(req),
		.reqReady(reqReady), .retireValid(retireValid), .retireTag(retireTag), .oldestValid(oldestValid),
		.oldestTag(oldestTag), .moveDoneValid(moveDoneValid), .moveDoneTag(moveDoneTag), .disp(disp),
		.execGo(execGo), .flush(flush), .moveBlock(moveBlock), .serialBlock(serialBlock), .unitFree(unitFree),
		.result(result));
	isc_core_model isc_core_model_i (.clock(clock), .rstn(rstn), .disp(disp), .execGo(execGo), .slow(slow),
		.retireValid(retireValid), .retireTag(retireTag), .oldestValid(oldestValid), .oldestTag(oldestTag),
		.moveDoneValid(moveDoneValid), .moveDoneTag(moveDoneTag));
	////////////////////////////////////////////////////////////////
	task automatic conclude();
		$display("compares %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	always @(posedge clock) begin
		if (result[UNIT_FIXED].gprValid === 1'b1) gprAt = cycles;
		if (result[UNIT_FIXED].crValid === 1'b1) crAt = cycles;
		if (retireValid === 1'b1) nRet++;
		if (moveDoneValid === 1'b1) nMove++;
		if (flush.valid === 1'b1) begin
			nFlush++;
			flushTag = flush.tag;
		end
		cycles++;
		if (cycles == 5000) begin
			miscompares++;
			conclude();
		end
	end
	task automatic cmpBit(input logic got, input logic exp);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cmpNum(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	function automatic isc_req_s mk(input logic [TAG_W-1:0] t, input isc_ser_e c, input logic [UNIT_W-1:0] u);
		return '{tag:t, serClass:c, unit:u, execTime:CNT_ONE, latGpr:CNT_ONE, latCr:CNT_ONE, wordCount:WORD_ONE,
			default:'0};
	endfunction
	// holds the request until its first word is dispatched
	task automatic send(input isc_req_s r);
		int n;
		n = 0;
		@(negedge clock);
		req = r;
		reqValid = 1'b1;
		while (!(disp.valid === 1'b1 && disp.tag === r.tag && disp.word === WORD_ZERO) && n < 200) begin
			@(negedge clock);
			n++;
		end
		cmpBit(n < 200, 1'b1);
		reqValid = 1'b0;
	endtask
	task automatic setMode(input isc_mode_e m, input logic s);
		int n;
		n = 0;
		while ((oldestValid !== 1'b0 || reqReady !== 1'b1) && n < 300) begin
			@(negedge clock);
			n++;
		end
		mode = m;
		slow = s;
		repeat (2) @(negedge clock);
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_tagflow();
		setMode(MODE_TAGFLOW, 1'b0);
		send(mk(4'h1, SER_COMPLETION, UNIT_FIXED));
		cmpBit(disp.held | serialBlock, 1'b0);
		send(mk(4'h2, SER_SYNC, UNIT_FIXED));
		cmpBit(serialBlock, 1'b1);
	endtask
	task automatic t_serial(input isc_ser_e c);
		int r0, f0;
		setMode(MODE_INORDER, 1'b1);
		send(mk(4'h5, c, UNIT_FIXED));
		r0 = nRet;
		f0 = nFlush;
		cmpBit(serialBlock, 1'b1);
		cmpBit(reqReady, 1'b0);
		send(mk(4'h6, SER_NONE, UNIT_FIXED));
		cmpNum(nRet - r0, 1);
		cmpNum(nFlush - f0, (c == SER_REFETCH) ? 1 : 0);
		if (c == SER_REFETCH) cmpNum(32'(flushTag), 32'h5);
	endtask
	task automatic t_hold(input isc_mode_e m);
		isc_req_s r;
		int n;
		setMode(m, 1'b1);
		send(mk(4'h3, SER_NONE, UNIT_FIXED));
		r = mk(4'h4, SER_NONE, UNIT_SYSREG);
		r.isCrLogic = 1'b1;
		send(r);
		cmpBit(disp.held, 1'b1);
		n = 0;
		while (execGo.valid !== 1'b1 && n < 50) begin
			@(negedge clock);
			n++;
		end
		cmpBit(n > 2 && n < 50, 1'b1);
		cmpNum(32'(execGo.tag), 32'h4);
		@(negedge clock);
		cmpBit(result[UNIT_SYSREG].gprValid, 1'b1);
		cmpNum(32'(result[UNIT_SYSREG].tag), 32'h4);
	endtask
	task automatic t_post();
		setMode(MODE_OOO, 1'b0);
		send(mk(4'h7, SER_POSTDISPATCH, UNIT_FIXED));
		cmpBit(flush.valid, 1'b1);
		cmpNum(32'(flush.tag), 32'h7);
	endtask
	task automatic t_string();
		isc_req_s r;
		r = mk(4'h8, SER_STRMULT, UNIT_LOADSTORE);
		r.wordCount = 5'h03;
		send(r);
		for (int w = 0; w < 3; w++) begin
			cmpBit(disp.valid, 1'b1);
			cmpNum(32'(disp.word), w);
			cmpBit(disp.last, w == 2);
			@(negedge clock);
		end
		cmpBit(disp.valid, 1'b0);
	endtask
	task automatic t_move();
		isc_req_s r;
		int m0;
		setMode(MODE_OOO, 1'b1);
		r = mk(4'h9, SER_NONE, UNIT_SYSREG);
		r.isMove = 1'b1;
		send(r);
		m0 = nMove;
		cmpBit(moveBlock, 1'b1);
		r = mk(4'ha, SER_EXECUTION, UNIT_FIXED);
		r.isBranch = 1'b1;
		send(r);
		cmpNum(nMove - m0, 1);
		cmpBit(serialBlock | disp.held, 1'b0);
		cmpNum(32'(disp.unit), 32'(UNIT_BRANCH));
	endtask
	task automatic t_timing();
		isc_req_s r;
		int c0;
		setMode(MODE_INORDER, 1'b0);
		r = mk(4'hb, SER_NONE, UNIT_FIXED);
		r.execTime = 6'h03;
		r.latGpr = 6'h02;
		r.latCr = 6'h04;
		r.recording = 1'b1;
		send(r);
		c0 = cycles;
		cmpBit(unitFree[UNIT_FIXED], 1'b0);
		repeat (6) @(negedge clock);
		cmpNum(gprAt - c0, 2);
		cmpNum(crAt - c0, 4);
		r.tag = 4'hc;
		send(r);
		c0 = cycles;
		send(mk(4'hd, SER_NONE, UNIT_FIXED));
		cmpNum(cycles - c0, 3);
	endtask
	initial begin
		repeat (8) @(negedge clock);
		rstn = 1'b1;
		repeat (2) @(negedge clock);
		t_tagflow();
		t_serial(SER_DISPATCH);
		t_serial(SER_REFETCH);
		t_hold(MODE_INORDER);
		t_hold(MODE_OOO);
		t_post();
		t_string();
		t_move();
		t_timing();
		conclude();
	end
endmodule // tb_top
